// [core/sfs_supervisor.sv]
// switch fault supervisor with apb status and interrupt
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter bit FOLDBACK = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // host pins
  input wire logic enable_in,
  input wire logic latch_sel_in,
  input wire logic standby_in,
  input wire logic sense_select_in,
  // detectors and analog readings
  input wire sfs_sense_t sense_in,
  input wire logic [11:0] measure_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // switch and diagnostics
  output logic switch_on_out,
  output logic [11:0] sense_output_out,
  output logic fault_out,
  output logic [11:0] current_limit_threshold_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfs_state_t state, next_state;
  logic therm_abs, therm_rel, ovc_flag;
  logic [3:0] fault_cnt;
  logic retry_start, retry_done;
  logic was_clean_on;
  logic [7:0] status, mask;
  logic [11:0] limit_prog;
  logic trigger, faults_clear;
  logic apb_wr, apb_rd, addr_ok;
  logic [7:0] status_ev;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    addr_hit = (a == r);
  endfunction

  // only thermal and overcurrent cause shutdown
  assign trigger = sense_in.abs_over | sense_in.rel_over | sense_in.cur_at_limit;
  assign faults_clear = !therm_abs && !therm_rel && !ovc_flag && !trigger;

  sfs_retry_timer u_retry (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(retry_start),
    .expired_out(retry_done)
  );

  // ----------------------------------------------------------------
  // fault flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      therm_abs <= 1'b0;
      therm_rel <= 1'b0;
      ovc_flag <= 1'b0;
    end else begin
      if (sense_in.abs_over) begin
        therm_abs <= 1'b1;
      end else if (sense_in.abs_below_hys) begin
        therm_abs <= 1'b0;
      end
      if (sense_in.rel_over) begin
        therm_rel <= 1'b1;
      end else if (retry_done) begin
        therm_rel <= 1'b0;
      end
      if (sense_in.cur_at_limit) begin
        ovc_flag <= 1'b1;
      end else if (retry_done) begin
        ovc_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  // retry counter starts only on entry to fault, so it never restarts while held
  assign retry_start = (state != SFS_FAULT) && (next_state == SFS_FAULT);

  always_comb begin
    next_state = state;
    unique case (state)
      SFS_OFF: begin
        if (enable_in && !sense_in.load_dump) begin
          next_state = SFS_ON;
        end
      end
      SFS_ON: begin
        if (trigger) begin
          next_state = SFS_FAULT;
        end else if (!enable_in && !sense_in.load_dump) begin
          next_state = SFS_OFF;
        end
      end
      SFS_FAULT: begin
        // latch select high holds off even after faults clear
        if (!latch_sel_in && retry_done && faults_clear) begin
          next_state = enable_in ? SFS_RETRY : SFS_OFF;
        end
      end
      SFS_RETRY: begin
        if (trigger) begin
          next_state = SFS_FAULT;
        end else if (sense_in.out_near_supply) begin
          next_state = SFS_ON;
        end else if (!enable_in) begin
          next_state = SFS_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state <= SFS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // foldback counting
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      fault_cnt <= CNT_RESET;
      was_clean_on <= 1'b0;
    end else if (standby_in) begin
      fault_cnt <= CNT_RESET;
      was_clean_on <= 1'b0;
    end else begin
      if (state == SFS_ON && next_state == SFS_OFF && was_clean_on) begin
        fault_cnt <= CNT_RESET;
      end else if (retry_start && fault_cnt != FOLD_COUNT) begin
        fault_cnt <= fault_cnt + 4'h1;
      end
      if (state == SFS_OFF && next_state == SFS_ON) begin
        was_clean_on <= 1'b1;
      end else if (retry_start || state == SFS_RETRY) begin
        was_clean_on <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      switch_on_out <= 1'b0;
      fault_out <= 1'b0;
      sense_output_out <= SENSE_RESET;
      current_limit_threshold_out <= DEFAULT_LIMIT;
    end else begin
      switch_on_out <= (next_state == SFS_ON) || (next_state == SFS_RETRY);
      fault_out <= (next_state == SFS_FAULT) || (next_state == SFS_RETRY);
      if (next_state == SFS_FAULT || next_state == SFS_RETRY) begin
        sense_output_out <= FAULT_SENSE_LEVEL;
      end else begin
        sense_output_out <= sense_select_in ? measure_in : measure_in;
      end
      // bad resistor overrides the programmed value
      if (sense_in.limit_res_bad) begin
        current_limit_threshold_out <= DEFAULT_LIMIT;
      end else if (FOLDBACK && fault_cnt == FOLD_COUNT) begin
        current_limit_threshold_out <= {1'b0, limit_prog[11:1]};
      end else begin
        current_limit_threshold_out <= limit_prog;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb registers and interrupt
  // ----------------------------------------------------------------
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && penable_in && !pwrite_in;
  assign addr_ok = addr_hit(paddr_in, ADDR_CTRL) || addr_hit(paddr_in, ADDR_STATUS) ||
                   addr_hit(paddr_in, ADDR_MASK) || addr_hit(paddr_in, ADDR_STATE) ||
                   addr_hit(paddr_in, ADDR_LIMIT);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mask <= MASK_RESET;
      limit_prog <= LIMIT_RESET;
    end else if (apb_wr && pready_out) begin
      if (addr_hit(paddr_in, ADDR_MASK)) begin
        mask <= pwdata_in[7:0];
      end
      if (addr_hit(paddr_in, ADDR_LIMIT)) begin
        limit_prog <= pwdata_in[11:0];
      end
    end
  end

  // events of this cycle, one bit per status position
  always_comb begin
    status_ev = '0;
    status_ev[ST_THERM] = retry_start && (sense_in.abs_over || sense_in.rel_over);
    status_ev[ST_OVC] = retry_start && sense_in.cur_at_limit;
    status_ev[ST_SHORT] = sense_in.cur_deglitched;
    status_ev[ST_FOLD] = retry_start && fault_cnt == FOLD_COUNT - 4'h1;
    status_ev[ST_RELEASE] = state == SFS_FAULT && next_state != SFS_FAULT;
  end

  // set wins over read-clear in the clearing cycle; an event set in the first access cycle is cleared unread
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      status <= STATUS_RESET;
    end else if (apb_rd && pready_out && addr_hit(paddr_in, ADDR_STATUS)) begin
      status <= status_ev;
    end else begin
      status <= status | status_ev;
    end
  end

  // one wait state: pready rises after the first access cycle, drops after
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask);
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !addr_ok;
      prdata_out <= 32'h0000_0000;
      if (apb_rd && !pready_out) begin
        if (addr_hit(paddr_in, ADDR_STATUS)) begin
          prdata_out <= {24'h00_0000, status};
        end else if (addr_hit(paddr_in, ADDR_MASK)) begin
          prdata_out <= {24'h00_0000, mask};
        end else if (addr_hit(paddr_in, ADDR_LIMIT)) begin
          prdata_out <= {20'h0_0000, limit_prog};
        end else if (addr_hit(paddr_in, ADDR_STATE)) begin
          prdata_out <= {12'h000, current_limit_threshold_out, fault_cnt, 2'b00, state};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  trip_off_a: assert property (
    (state == SFS_ON && sense_in.cur_at_limit) |=> !switch_on_out)
    else $error("switch not off after current limit");
  fault_ind_a: assert property ((state == SFS_ON && trigger) |=> fault_out)
    else $error("fault not shown after trigger");
  fault_level_a: assert property (
    state == SFS_FAULT |-> sense_output_out == FAULT_SENSE_LEVEL)
    else $error("sense not at fault level");
  latch_hold_a: assert property (
    (state == SFS_FAULT && latch_sel_in) |=> state == SFS_FAULT)
    else $error("left fault with latch select high");
  release_a: assert property (
    (state == SFS_FAULT && $past(state) == SFS_FAULT && next_state != SFS_FAULT) |->
    (retry_done && !latch_sel_in && faults_clear))
    else $error("released without all conditions");
  retry_hold_a: assert property (
    (state == SFS_RETRY && !sense_in.out_near_supply && !trigger && enable_in) |=> fault_out)
    else $error("fault indication dropped during retry");
  fold_sat_a: assert property (fault_cnt <= FOLD_COUNT)
    else $error("fault counter beyond saturation");
  fold_half_a: assert property (
    (FOLDBACK && fault_cnt == FOLD_COUNT && !sense_in.limit_res_bad) |=>
    current_limit_threshold_out == {1'b0, $past(limit_prog[11:1])})
    else $error("foldback limit not halved");
  dump_hold_a: assert property (
    (state == SFS_ON && sense_in.load_dump && !trigger) |=> state == SFS_ON)
    else $error("switch changed during load dump");
  no_spur_off_a: assert property (
    (state == SFS_ON && !trigger && enable_in) |=> switch_on_out)
    else $error("switch dropped without a trigger");
  norm_sense_a: assert property (
    (next_state == SFS_ON || next_state == SFS_OFF) |=> sense_output_out == $past(measure_in))
    else $error("measurement not shown outside fault");
  release_ind_a: assert property (
    (state == SFS_FAULT && !(retry_done && !latch_sel_in && faults_clear)) |=> fault_out)
    else $error("fault indication cleared too early");
  therm_trip_a: assert property (
    (state == SFS_ON && (sense_in.abs_over || sense_in.rel_over)) |=>
    (fault_out && !switch_on_out))
    else $error("no shutdown on thermal trigger");
  abs_hold_a: assert property (
    (therm_abs && !sense_in.abs_below_hys) |=> therm_abs)
    else $error("absolute thermal fault cleared before hysteresis");
  rel_clear_a: assert property (
    (therm_rel && !sense_in.rel_over && retry_done) |=> !therm_rel)
    else $error("relative thermal fault not cleared after interval");
  short_evt_a: assert property (
    sense_in.cur_deglitched |=> status[ST_SHORT])
    else $error("short circuit event not recorded");
  fold_clear_a: assert property (
    standby_in |=> fault_cnt == CNT_RESET)
    else $error("fault count kept through standby");
  fixed_lim_a: assert property (
    (!FOLDBACK && !sense_in.limit_res_bad) |=> current_limit_threshold_out == $past(limit_prog))
    else $error("fixed variant limit moved");
  bad_res_a: assert property (
    sense_in.limit_res_bad |=> current_limit_threshold_out == DEFAULT_LIMIT)
    else $error("default limit not used for bad resistor");
  retry_keep_a: assert property (
    (state == SFS_FAULT && retry_done) |=> retry_done)
    else $error("retry interval restarted while held");

  fault_cv: cover property (state == SFS_FAULT ##1 state == SFS_RETRY);
  release_cv: cover property (state == SFS_RETRY ##1 state == SFS_ON);
  fold_cv: cover property (fault_cnt == FOLD_COUNT);
  irq_cv: cover property (irq_out);
endmodule

// [core/sfs_pkg.sv]
// package: constants and carrier types for the switch fault supervisor
// Contract
// - switch turns off automatically on thermal or overcurrent trigger only
// - a trigger while on or in retry enters fault state; sense output shows fault, not measurement
// - release needs latch select low, retry interval elapsed, all faults clear
// - thermal fault on absolute temperature limit or relative temperature limit
// - absolute fault clears after hysteresis; relative fault clears after retry interval
// - current limit reached switches channel off at once, no timer
// - short-circuit event recorded when deglitched current exceeds the limit
// - in fault state sense output drives the fault sense level
// - foldback variant halves the limit after seven consecutive fault shutdowns
// - foldback restored and count cleared on standby or clean on-off cycle
// - variant without foldback keeps its current limit fixed
// - bad limit resistor reading selects internal default current limit
// - on and off states are held through a supply load-dump transient
// - latch select high keeps switch off after fault until it goes low
// - after retry fault indication holds until output rises near supply, or until enable goes low and the switch turns off
package sfs_pkg;
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RETRY_US = 1;
  localparam int unsigned RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int unsigned RETRY_W = 16;
  localparam logic [3:0] FOLD_COUNT = 4'h7;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int unsigned LIMIT_W = 12;
  localparam logic [11:0] DEFAULT_LIMIT = 12'h0_100;
  localparam logic [11:0] FAULT_SENSE_LEVEL = 12'hF_FF;
  localparam logic [11:0] SENSE_RESET = 12'h0_000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [11:0] ADDR_CTRL = 12'h0_000;
  localparam logic [11:0] ADDR_STATUS = 12'h0_004;
  localparam logic [11:0] ADDR_MASK = 12'h0_008;
  localparam logic [11:0] ADDR_STATE = 12'h0_00C;
  localparam logic [11:0] ADDR_LIMIT = 12'h0_010;
  localparam logic [11:0] LIMIT_RESET = 12'h0_200;
  // status bit positions
  localparam int unsigned ST_THERM = 0;
  localparam int unsigned ST_OVC = 1;
  localparam int unsigned ST_SHORT = 2;
  localparam int unsigned ST_FOLD = 3;
  localparam int unsigned ST_RELEASE = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFS_OFF = 2'b00,
    SFS_ON = 2'b01,
    SFS_FAULT = 2'b10,
    SFS_RETRY = 2'b11
  } sfs_state_t;

  typedef struct packed {
    logic abs_over;
    logic abs_below_hys;
    logic rel_over;
    logic cur_at_limit;
    logic cur_deglitched;
    logic out_near_supply;
    logic limit_res_bad;
    logic load_dump;
  } sfs_sense_t;
endpackage

// [core/sfs_retry_timer.sv]
// retry interval counter for the switch fault supervisor
module sfs_retry_timer
  import sfs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic start_in,
  output logic expired_out
);
  logic [RETRY_W-1:0] count;

  // started once per shutdown; holds expired until next start
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      count <= '0;
      expired_out <= 1'b0;
    end else if (start_in) begin
      count <= RETRY_W'(RETRY_CYC - 1);
      expired_out <= 1'b0;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end else begin
      expired_out <= 1'b1;
    end
  end
endmodule

// [test/sfs_host_model.sv]
// host controller model driving the switch request pins
module sfs_host_model (
  // clock
  input wire logic ref_clk_in,
  // commands from the bench
  input wire logic supply_ok_in,
  input wire logic want_on_in,
  input wire logic want_latch_in,
  // pins toward the supervisor
  output logic enable_out,
  output logic latch_sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    enable_out = 1'b0;
    latch_sel_out = 1'b0;
  end
  // a slow supply ramp must not see an early enable
  always @(posedge ref_clk_in) begin
    enable_out <= want_on_in & supply_ok_in;
    latch_sel_out <= want_latch_in;
  end
endmodule

// [test/tb_top.sv]
// self-checking bench for the switch fault supervisor
module tb_top
  import sfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus, model state and instances
  // ----------------------------------------------------------------
  logic clk;
  logic rst_n = 1'b0;
  logic want_on = 1'b1;
  logic want_latch = 1'b0;
  logic supply_ok = 1'b0;
  logic standby = 1'b0;
  logic sense_sel = 1'b0;
  sfs_sense_t sense = 8'h44;
  logic [11:0] measure = 12'h0_000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0_000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic enable, latch_sel, pready, pslverr, sw_on, fault, irq;
  logic [31:0] prdata, q;
  logic [11:0] sense_output, limit, limit_b;
  logic e;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int fold_cnt = 0;
  int n;
  logic [11:0] prog_lim = LIMIT_RESET;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sfs_host_model host (.ref_clk_in(clk), .supply_ok_in(supply_ok), .want_on_in(want_on),
    .want_latch_in(want_latch), .enable_out(enable), .latch_sel_out(latch_sel));
  sfs_supervisor #(.FOLDBACK(1'b1)) dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .enable_in(enable), .latch_sel_in(latch_sel), .standby_in(standby),
    .sense_select_in(sense_sel), .sense_in(sense), .measure_in(measure), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .switch_on_out(sw_on),
    .sense_output_out(sense_output), .fault_out(fault), .current_limit_threshold_out(limit),
    .irq_out(irq));
  // fixed-limit variant shares every input
  sfs_supervisor #(.FOLDBACK(1'b0)) dut_b (.ref_clk_in(clk), .rst_n_in(rst_n),
    .enable_in(enable), .latch_sel_in(latch_sel), .standby_in(standby),
    .sense_select_in(sense_sel), .sense_in(sense), .measure_in(measure), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(), .pready_out(), .pslverr_out(), .switch_on_out(), .sense_output_out(),
    .fault_out(), .current_limit_threshold_out(limit_b), .irq_out());

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 1200 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(pready, 1'b1, "apb answer");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [11:0] exp_lim();
    return (fold_cnt >= 7) ? prog_lim >> 1 : prog_lim;
  endfunction

  // kind 0 overcurrent, 1 absolute thermal, 2 relative thermal
  task automatic trip(input int kind);
    sense.cur_at_limit <= (kind == 0);
    sense.cur_deglitched <= (kind == 0);
    sense.abs_over <= (kind == 1);
    sense.abs_below_hys <= (kind != 1);
    sense.rel_over <= (kind == 2);
    @(posedge clk);
    sense.cur_at_limit <= 1'b0;
    sense.cur_deglitched <= 1'b0;
    sense.abs_over <= 1'b0;
    sense.rel_over <= 1'b0;
    @(posedge clk);
    chk({sw_on, fault}, 2'b01, "trip response");
    chk(sense_output, FAULT_SENSE_LEVEL, "fault sense level");
    fold_cnt = (fold_cnt < 7) ? fold_cnt + 1 : 7;
  endtask

  task automatic wait_clear(input int lim);
    n = 0;
    while (fault !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  initial begin
    void'($urandom(32'h36d3_9f2f));
    repeat (3) @(posedge clk);
    chk(limit, DEFAULT_LIMIT, "limit in reset");
    chk({sw_on, fault, irq}, 3'b000, "outputs in reset");
    chk(enable, 1'b0, "enable before supply");
    rst_n <= 1'b1;
    want_on <= 1'b0;
    supply_ok <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_LIMIT, 32'h0000_0000);
    chk(q, LIMIT_RESET, "limit register reset");
    apb(1'b0, ADDR_MASK, 32'h0000_0000);
    chk(q, MASK_RESET, "mask reset");
    chk(e, 1'b0, "mapped read error");
    apb(1'b0, 12'h0_040, 32'h0000_0000);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0000_0000, "unmapped read");
    apb(1'b1, ADDR_LIMIT, 32'h0000_0300);
    prog_lim = 12'h3_00;
    repeat (3) @(posedge clk);
    chk(limit, exp_lim(), "programmed limit");
    sense.limit_res_bad <= 1'b1;
    repeat (3) @(posedge clk);
    chk(limit, DEFAULT_LIMIT, "bad resistor default");
    sense.limit_res_bad <= 1'b0;
    want_on <= 1'b1;
    measure <= 12'($urandom);
    sense_sel <= 1'($urandom);
    repeat (6) @(posedge clk);
    chk({sw_on, sense_output}, {1'b1, measure}, "normal measurement");
    sense.load_dump <= 1'b1;
    want_on <= 1'b0;
    repeat (10) @(posedge clk);
    chk({sw_on, fault}, 2'b10, "load dump hold");
    sense.load_dump <= 1'b0;
    repeat (6) @(posedge clk);
    chk(sw_on, 1'b0, "off after load dump");
    want_on <= 1'b1;
    $display("test registers and load dump done");
    apb(1'b1, ADDR_MASK, 32'h0000_0006);
    want_latch <= 1'b1;
    repeat (4) @(posedge clk);
    trip(0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "interrupt raised");
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0006, 32'h0000_0006, "short event status");
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "interrupt cleared by read");
    repeat (150) @(posedge clk);
    chk(fault, 1'b1, "latched off");
    want_latch <= 1'b0;
    wait_clear(10);
    chk(fault, 1'b0, "release after latch low");
    $display("test latch and interrupt done");
    want_on <= 1'b0;
    repeat (4) @(posedge clk);
    want_on <= 1'b1;
    repeat (4) @(posedge clk);
    want_on <= 1'b0;
    repeat (4) @(posedge clk);
    fold_cnt = 0;
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    chk(q[7:4], 4'(fold_cnt), "count after clean cycle");
    chk(q[19:8], exp_lim(), "limit field after clean cycle");
    want_on <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      repeat (3) @(posedge clk);
      trip(k);
      if (k == 1) begin
        repeat (150) @(posedge clk);
        chk(fault, 1'b1, "held until hysteresis");
        sense.abs_below_hys <= 1'b1;
      end
      wait_clear(200);
      chk(k == 1 ? n < 10 : (n >= RETRY_CYC - 10 && n <= RETRY_CYC + 15), 1'b1,
        "retry interval");
    end
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(q[ST_THERM], 1'b1, "thermal status");
    chk(q[ST_RELEASE], 1'b1, "release status");
    $display("test retry timing done");
    repeat (4) begin
      repeat (3) @(posedge clk);
      chk(limit, exp_lim(), "limit before trip");
      chk(limit_b, prog_lim, "fixed variant");
      trip(0);
      wait_clear(200);
    end
    repeat (3) @(posedge clk);
    chk(limit, exp_lim(), "folded limit");
    chk(limit_b, prog_lim, "fixed variant");
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(q[ST_FOLD], 1'b1, "foldback status");
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    standby <= 1'b0;
    fold_cnt = 0;
    repeat (6) @(posedge clk);
    chk(limit, exp_lim(), "limit restored");
    $display("test foldback done");
    sense.out_near_supply <= 1'b0;
    trip(0);
    wait_clear(150);
    chk({sw_on, fault}, 2'b11, "indication during retry");
    sense.out_near_supply <= 1'b1;
    wait_clear(10);
    chk(fault, 1'b0, "indication cleared");
    $display("test retry indication done");
    conclude();
  end
endmodule
